//--- tcir_pkg.sv
package tcir_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Input routing register
  localparam logic [15:0] TCIR_ROUTE_ADDR      = 16'hFF4F;
  localparam logic [7:0]  TCIR_ROUTE_RESET     = 8'h00;
  localparam logic [7:0]  TCIR_ROUTE_MASK      = 8'h3F;
  localparam int          TCIR_BIT_IRQ_SRC     = 0;
  localparam int          TCIR_BIT_TRIG_SRC    = 1;
  localparam int          TCIR_BIT_GATE_CTRL   = 2;
  localparam int          TCIR_BIT_RX_EN       = 3;
  localparam int          TCIR_BIT_ROUTE_LO    = 4;
  localparam int          TCIR_BIT_ROUTE_HI    = 5;
  localparam logic [1:0]  TCIR_ROUTE_DEDICATED = 2'h0;
  localparam logic [1:0]  TCIR_ROUTE_SHARED    = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Valid edge codes and prescaler
  localparam logic [1:0]  TCIR_EDGE_FALL       = 2'h0;
  localparam logic [1:0]  TCIR_EDGE_RISE       = 2'h1;
  localparam logic [1:0]  TCIR_EDGE_NONE       = 2'h2;
  localparam logic [1:0]  TCIR_EDGE_BOTH       = 2'h3;
  localparam logic [3:0]  TCIR_DIV_BASE        = 4'h2;
  localparam logic        TCIR_RX_BLOCKED_LVL  = 1'b1;
  localparam logic [15:0] TCIR_CNT_RESET       = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic        bit_wr;
    logic [2:0]  bit_idx;
    logic [7:0]  wdata;
  } tcir_bus_t;

  typedef struct packed {
    logic        run;
    logic        clear_start;
    logic        count_on_trig;
    logic        cr0_capture;
    logic        reverse_phase;
    logic        out_en;
    logic [1:0]  presc_sel;
    logic [1:0]  pri_edge;
    logic [1:0]  sec_edge;
    logic [15:0] compare;
  } tcir_cfg_t;

  typedef struct packed {
    logic serial_receive_pin;
    logic shared_rx_pin;
    logic primary_trigger_pin;
    logic secondary_trigger_in;
    logic external_irq_pin;
    logic second_timer_count_in;
    logic gate_timer_out;
  } tcir_pins_t;

  localparam int TCIR_NPINS = 7;

endpackage : tcir_pkg

//--- tcir_edge_filter.sv
`timescale 1ns/1ns
module tcir_edge_filter
  import tcir_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  input  wire logic run_in,
  input  wire logic first_run_in,
  input  wire logic sample_en_in,
  input  wire logic level_in,
  output logic      rise_out,
  output logic      fall_out
);

  logic stable_r;
  logic prev_r;
  logic run_d_r;
  wire  start_w   = run_in & ~run_d_r;
  wire  confirm_w = run_in & sample_en_in & (level_in == prev_r)
                    & (level_in != stable_r);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      stable_r <= 1'b0;
      prev_r   <= 1'b0;
      run_d_r  <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else
    begin
      run_d_r  <= run_in;
      rise_out <= confirm_w & level_in;
      fall_out <= confirm_w & ~level_in;
      // First start sees a high pin as rising; later starts do not
      if (start_w)
      begin
        stable_r <= first_run_in ? 1'b0 : level_in;
        prev_r   <= first_run_in ? 1'b0 : level_in;
      end
      else if (run_in && sample_en_in)
      begin
        prev_r <= level_in;
        if (confirm_w)
          stable_r <= level_in;
      end
    end
  end

endmodule : tcir_edge_filter

//--- tcir_core.sv
`timescale 1ns/1ns
// Contract
// - In clear-and-start mode a primary valid edge copies the count into the secondary capture register and clears the count.
// - In compare mode a count equal to the compare value raises the primary interrupt and, with the output enabled, toggles the timer output.
// - A primary trigger used as count clock cannot also trigger a capture, so that combination is blocked.
// - Captures happen on the count clock's falling edge and their interrupts on the next rising edge.
// - A reverse-phase capture into the primary register raises no interrupt.
// - In reverse-phase mode a secondary edge captures nothing but raises the primary interrupt.
// - On the first start after reset a high trigger pin counts as a rising edge.
// - On a later restart a high trigger pin is not a rising edge.
// - The primary filter samples on the system clock as count source and on the count clock as capture trigger.
// - A valid edge needs the new level on two consecutive samples.
// - While stopped the trigger inputs give no edge, capture or count.
// - The serial route field takes only the dedicated or the shared pair code.
// - The receive-enable bit blocks or passes the dedicated receive pin.
// - Two bits route the receive line to the external interrupt and primary trigger.
// - A bit gates the second timer's count input with another timer's output.
// - The 8-bit routing register sits at its fixed address, resets to zero and reads its top bits as zero.
module tcir_core
  import tcir_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire tcir_bus_t   bus_in,
  input  wire tcir_cfg_t   cfg_in,
  input  wire tcir_pins_t  pins_in,
  output logic [7:0]       rdata_out,
  output logic [15:0]      timer_counter_value_out,
  output logic [15:0]      primary_capcomp_reg_out,
  output logic [15:0]      secondary_capture_reg_out,
  output logic             primary_match_irq_out,
  output logic             secondary_match_irq_out,
  output logic             timer_output_pin_out,
  output logic             routed_rx_out,
  output logic             routed_ext_irq_out,
  output logic             second_timer_count_out,
  output logic             tx_on_shared_out,
  output logic             cfg_conflict_out
);

  function automatic logic [3:0] div_limit(input logic [1:0] sel);
    div_limit = 4'((TCIR_DIV_BASE << sel) - 4'h1);
  endfunction : div_limit

  function automatic logic edge_ok(input logic [1:0] sel,
                                   input logic rise,
                                   input logic fall);
    edge_ok = ((sel == TCIR_EDGE_RISE || sel == TCIR_EDGE_BOTH) && rise)
            | ((sel == TCIR_EDGE_FALL || sel == TCIR_EDGE_BOTH) && fall);
  endfunction : edge_ok

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  tcir_pins_t pins_s1_r;
  tcir_pins_t pins_s2_r;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
    end
    else
    begin
      pins_s1_r <= pins_in;
      pins_s2_r <= pins_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Routing register
  logic [7:0] route_r;
  wire        route_hit_w = (bus_in.addr == TCIR_ROUTE_ADDR);
  wire  [7:0] bit_mask_w  = 8'h01 << bus_in.bit_idx;
  wire  [7:0] bit_val_w   = bus_in.wdata[0] ? (route_r | bit_mask_w)
                                            : (route_r & ~bit_mask_w);
  wire  [7:0] wr_val_w    = bus_in.bit_wr ? bit_val_w : bus_in.wdata;
  wire  [1:0] wr_route_w  = wr_val_w[TCIR_BIT_ROUTE_HI:TCIR_BIT_ROUTE_LO];
  // Prohibited pin codes leave the old route so pins never float
  wire        route_ok_w  = (wr_route_w == TCIR_ROUTE_DEDICATED)
                          | (wr_route_w == TCIR_ROUTE_SHARED);
  wire        do_wr_w     = route_hit_w & (bus_in.wr | bus_in.bit_wr);
  wire  [7:0] route_nxt   = route_ok_w ? (wr_val_w & TCIR_ROUTE_MASK)
                          : ({wr_val_w[7:6], route_r[5:4], wr_val_w[3:0]}
                             & TCIR_ROUTE_MASK);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      route_r <= TCIR_ROUTE_RESET;
    else if (do_wr_w)
      route_r <= route_nxt;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!sys_rst_in && bus_in.rd && route_hit_w)
      rdata_out <= route_r & TCIR_ROUTE_MASK;
    else
      rdata_out <= 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // Signal routing
  wire shared_sel_w = route_r[TCIR_BIT_ROUTE_HI];
  wire ded_rx_w     = route_r[TCIR_BIT_RX_EN] ? pins_s2_r.serial_receive_pin
                                              : TCIR_RX_BLOCKED_LVL;
  wire rx_w         = shared_sel_w ? pins_s2_r.shared_rx_pin : ded_rx_w;
  wire pri_src_w    = route_r[TCIR_BIT_TRIG_SRC] ? rx_w
                                                 : pins_s2_r.primary_trigger_pin;
  wire ext_src_w    = route_r[TCIR_BIT_IRQ_SRC] ? rx_w
                                                : pins_s2_r.external_irq_pin;
  wire gated_cnt_w  = route_r[TCIR_BIT_GATE_CTRL]
                    ? (pins_s2_r.second_timer_count_in
                       & pins_s2_r.gate_timer_out)
                    : pins_s2_r.second_timer_count_in;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      routed_rx_out          <= TCIR_RX_BLOCKED_LVL;
      routed_ext_irq_out     <= 1'b0;
      second_timer_count_out <= 1'b0;
      tx_on_shared_out       <= 1'b0;
    end
    else
    begin
      routed_rx_out          <= rx_w;
      routed_ext_irq_out     <= ext_src_w;
      second_timer_count_out <= gated_cnt_w;
      tx_on_shared_out       <= shared_sel_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Prescaler: count clock as rise and fall enables
  logic [3:0] div_r;
  wire  [3:0] lim_w   = div_limit(cfg_in.presc_sel);
  wire        rise_en = cfg_in.run & (div_r == 4'h0);
  wire        fall_en = cfg_in.run
                        & (div_r == 4'(({1'b0, lim_w} + 5'h01) >> 1));

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !cfg_in.run || div_r >= lim_w)
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Edge detection
  logic ever_run_r;
  logic pri_rise;
  logic pri_fall;
  logic sec_rise;
  logic sec_fall;
  // Count source needs full-rate sampling, capture trigger the slow clock
  wire  pri_sample_w = cfg_in.count_on_trig | rise_en;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ever_run_r <= 1'b0;
    else if (cfg_in.run)
      ever_run_r <= 1'b1;
  end

  tcir_edge_filter u_pri_filter (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .run_in       (cfg_in.run),
    .first_run_in (~ever_run_r),
    .sample_en_in (pri_sample_w),
    .level_in     (pri_src_w),
    .rise_out     (pri_rise),
    .fall_out     (pri_fall)
  );

  tcir_edge_filter u_sec_filter (
    .clk_sys_in   (clk_sys_in),
    .sys_rst_in   (sys_rst_in),
    .run_in       (cfg_in.run),
    .first_run_in (~ever_run_r),
    .sample_en_in (rise_en),
    .level_in     (pins_s2_r.secondary_trigger_in),
    .rise_out     (sec_rise),
    .fall_out     (sec_fall)
  );

  wire pri_valid_w = edge_ok(cfg_in.pri_edge, pri_rise, pri_fall);
  // Opposite phase of the primary edge for reverse-phase capture
  wire pri_rev_w   = edge_ok(cfg_in.pri_edge, pri_fall, pri_rise);
  wire sec_valid_w = edge_ok(cfg_in.sec_edge, sec_rise, sec_fall);
  // Primary edge feeding the counter cannot also trigger captures
  wire pri_cap_ok  = ~cfg_in.count_on_trig;

  //////////////////////////////////////////////////////////////////////////
  // Pending capture events, applied on the falling count edge
  logic pend_clr_r;
  logic pend_rev_r;
  logic pend_sec_r;
  logic irq_pri_pend_r;
  logic irq_sec_pend_r;
  wire  rev_mode_w = cfg_in.cr0_capture & cfg_in.reverse_phase;

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !cfg_in.run)
    begin
      pend_clr_r <= 1'b0;
      pend_rev_r <= 1'b0;
      pend_sec_r <= 1'b0;
    end
    else
    begin
      // An event in a falling-edge cycle waits for the next fall
      pend_clr_r <= (pend_clr_r & ~fall_en) | (pri_valid_w & pri_cap_ok);
      pend_rev_r <= (pend_rev_r & ~fall_en)
                  | (pri_rev_w & pri_cap_ok & rev_mode_w);
      pend_sec_r <= (pend_sec_r & ~fall_en) | sec_valid_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter, captures, compare
  logic [15:0] cnt_nxt;
  logic        match_r;
  wire         tick_w = cfg_in.count_on_trig ? pri_valid_w : rise_en;
  wire         clr_w  = fall_en & pend_clr_r & cfg_in.clear_start;

  always_comb
  begin
    cnt_nxt = timer_counter_value_out;
    if (clr_w)
      cnt_nxt = TCIR_CNT_RESET;
    else if (tick_w)
      cnt_nxt = timer_counter_value_out + 16'h0001;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !cfg_in.run)
      timer_counter_value_out <= TCIR_CNT_RESET;
    else
      timer_counter_value_out <= cnt_nxt;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      primary_capcomp_reg_out   <= TCIR_CNT_RESET;
      secondary_capture_reg_out <= TCIR_CNT_RESET;
    end
    else
    begin
      if (!cfg_in.cr0_capture)
        primary_capcomp_reg_out <= cfg_in.compare;
      else if (fall_en && pend_rev_r)
        primary_capcomp_reg_out <= timer_counter_value_out;
      else if (fall_en && pend_sec_r && !rev_mode_w)
        primary_capcomp_reg_out <= timer_counter_value_out;
      if (fall_en && pend_clr_r)
        secondary_capture_reg_out <= timer_counter_value_out;
    end
  end

  // Capture interrupts wait for the next rising count edge
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !cfg_in.run)
    begin
      irq_pri_pend_r <= 1'b0;
      irq_sec_pend_r <= 1'b0;
    end
    else if (fall_en)
    begin
      irq_pri_pend_r <= cfg_in.cr0_capture & pend_sec_r;
      irq_sec_pend_r <= pend_clr_r;
    end
    else if (rise_en)
    begin
      irq_pri_pend_r <= 1'b0;
      irq_sec_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || !cfg_in.run)
      match_r <= 1'b0;
    else
      match_r <= ~cfg_in.cr0_capture & (tick_w | clr_w)
               & (cnt_nxt == cfg_in.compare);
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
    begin
      primary_match_irq_out   <= 1'b0;
      secondary_match_irq_out <= 1'b0;
      timer_output_pin_out    <= 1'b0;
      cfg_conflict_out        <= 1'b0;
    end
    else
    begin
      primary_match_irq_out   <= match_r
                               | (rise_en & irq_pri_pend_r);
      secondary_match_irq_out <= rise_en & irq_sec_pend_r;
      if (match_r && cfg_in.out_en)
        timer_output_pin_out <= ~timer_output_pin_out;
      cfg_conflict_out        <= cfg_in.count_on_trig
                               & (cfg_in.clear_start
                                  | rev_mode_w);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_isc_upper_zero: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) rdata_out[7:6] == 2'b00)
    else $error("routing register top bits not zero");
  a_route_code_legal: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) route_r[5:4] != 2'b01 && route_r[5:4] != 2'b11)
    else $error("prohibited serial route code held");
  a_rx_blocked: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (!route_r[TCIR_BIT_RX_EN] && !route_r[TCIR_BIT_ROUTE_HI])
      ##1 (!route_r[TCIR_BIT_RX_EN] && !route_r[TCIR_BIT_ROUTE_HI])
      |-> routed_rx_out == TCIR_RX_BLOCKED_LVL)
    else $error("blocked receive pin reached the routed line");
  a_gate_ctrl: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    (route_r[TCIR_BIT_GATE_CTRL] && !pins_s2_r.gate_timer_out)
      |=> !second_timer_count_out)
    else $error("gated count input passed while gate low");
  a_clear_on_edge: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) clr_w
      |=> timer_counter_value_out == TCIR_CNT_RESET
          && secondary_capture_reg_out == $past(timer_counter_value_out))
    else $error("clear-and-start did not capture and clear");
  a_match_toggle: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) (match_r && cfg_in.out_en)
      |=> primary_match_irq_out
          && timer_output_pin_out != $past(timer_output_pin_out))
    else $error("compare match missed interrupt or toggle");
  a_irq_on_rise: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    secondary_match_irq_out |-> $past(rise_en) && $past(irq_sec_pend_r))
    else $error("capture interrupt off the rising count edge");
  a_stopped_quiet: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) !cfg_in.run [*2]
      |-> !pri_rise && !sec_rise && !pri_fall && !sec_fall
          && timer_counter_value_out == TCIR_CNT_RESET)
    else $error("edge or count while timer stopped");
  a_rev_no_irq: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in || !cfg_in.run)
    (fall_en && rev_mode_w && pend_rev_r && !pend_sec_r) |=> !irq_pri_pend_r)
    else $error("reverse-phase capture raised an interrupt");

  c_clear_start: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) clr_w);
  c_match: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) match_r);
  c_rev_irq: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) rev_mode_w && primary_match_irq_out);
  c_shared_route: cover property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) tx_on_shared_out && route_r[TCIR_BIT_TRIG_SRC]);

endmodule : tcir_core

//--- tcir_pin_model.sv
`timescale 1ns/1ns
module tcir_pin_model
  import tcir_pkg::*;
(
  input  wire logic clk_sys_in,
  output tcir_pins_t pins_out
);

  initial pins_out = '0;

  task automatic set_pins(input tcir_pins_t val);
    @(posedge clk_sys_in);
    pins_out <= val;
  endtask : set_pins

  // Width below two count clocks is used only to probe noise rejection
  task automatic pulse_primary(input int width, input int gap);
    @(posedge clk_sys_in);
    pins_out.primary_trigger_pin <= 1'b1;
    repeat (width) @(posedge clk_sys_in);
    pins_out.primary_trigger_pin <= 1'b0;
    repeat (gap) @(posedge clk_sys_in);
  endtask : pulse_primary

  task automatic pulse_secondary(input int width, input int gap);
    @(posedge clk_sys_in);
    pins_out.secondary_trigger_in <= 1'b1;
    repeat (width) @(posedge clk_sys_in);
    pins_out.secondary_trigger_in <= 1'b0;
    repeat (gap) @(posedge clk_sys_in);
  endtask : pulse_secondary

endmodule : tcir_pin_model

//--- tb_timer_capture_input_routing.sv
`timescale 1ns/1ns
module tb_timer_capture_input_routing;
  import tcir_pkg::*;

  logic        clk_sys_in;
  logic        sys_rst_in;
  tcir_bus_t   bus;
  tcir_cfg_t   cfg;
  tcir_pins_t  pins;
  tcir_pins_t  p;
  logic [7:0]  rdata;
  logic [15:0] cnt;
  logic [15:0] cap0;
  logic [15:0] cap1;
  logic        irq0;
  logic        irq1;
  logic        tout;
  logic        rx;
  logic        ext;
  logic        cnt2;
  logic        tx_sh;
  logic        conflict;
  int          num_errors;
  int          comparisons;
  int          num_caps;
  int          num_irqs;
  int          num_cap0;
  int          exp_caps;
  int          seed;
  logic [31:0] v;
  logic [15:0] cnt_prev;
  logic [15:0] cap0_prev;
  logic        run_prev;
  logic        tout_prev;
  logic        exp_rx;
  logic [7:0]  model_reg;
  logic [7:0]  rv;
  logic [7:0]  tmp;

  tcir_core dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .bus_in(bus),
    .cfg_in(cfg), .pins_in(pins), .rdata_out(rdata),
    .timer_counter_value_out(cnt), .primary_capcomp_reg_out(cap0),
    .secondary_capture_reg_out(cap1), .primary_match_irq_out(irq0),
    .secondary_match_irq_out(irq1), .timer_output_pin_out(tout),
    .routed_rx_out(rx), .routed_ext_irq_out(ext),
    .second_timer_count_out(cnt2), .tx_on_shared_out(tx_sh),
    .cfg_conflict_out(conflict)
  );

  tcir_pin_model partner (
    .clk_sys_in(clk_sys_in),
    .pins_out  (pins)
  );

  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Refused route codes all have the low field bit set
  function automatic void model_write(input logic [7:0] d);
    model_reg[3:0] = d[3:0];
    if (!d[4])
      model_reg[5:4] = d[5:4];
    model_reg[7:6] = 2'b00;
  endfunction : model_write

  task automatic bus_op(input logic wr, input logic rd, input logic bw,
                        input logic [15:0] a, input logic [2:0] idx,
                        input logic [7:0] d);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wr: wr, rd: rd, bit_wr: bw, bit_idx: idx, wdata: d};
    @(posedge clk_sys_in);
    bus <= '0;
    #1 rv = rdata;
  endtask : bus_op

  task automatic reg_wr(input logic [7:0] d);
    bus_op(1'b1, 1'b0, 1'b0, TCIR_ROUTE_ADDR, 3'h0, d);
    model_write(d);
  endtask : reg_wr

  task automatic reg_bit(input logic [2:0] idx, input logic val);
    tmp = model_reg;
    tmp[idx] = val;
    bus_op(1'b0, 1'b0, 1'b1, TCIR_ROUTE_ADDR, idx, {7'h00, val});
    model_write(tmp);
  endtask : reg_bit

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
    bus_op(1'b0, 1'b1, 1'b0, a, 3'h0, 8'h00);
    check(rv, exp);
  endtask : reg_rd

  //////////////////////////////////////////////////////////////////////////
  // A clear shows as a drop to zero while running
  always @(negedge clk_sys_in)
  begin
    if (!sys_rst_in && cfg.run && run_prev && cnt === 16'h0000
        && cnt_prev !== 16'h0000)
    begin
      num_caps++;
      check(cap1, cnt_prev);
    end
    if (!sys_rst_in && cfg.cr0_capture && cap0 !== cap0_prev)
    begin
      num_cap0++;
      check(cap0, cnt_prev);
    end
    if (!sys_rst_in && irq0 === 1'b1)
    begin
      num_irqs++;
      if (!cfg.cr0_capture)
        check(16'(tout ^ tout_prev), 16'h0001);
      else
        check(16'(tout ^ tout_prev), 16'h0000);
    end
    cnt_prev = cnt;
    cap0_prev = cap0;
    run_prev = cfg.run;
    tout_prev = tout;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys_in);
    num_errors++;
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'h1309;
    sys_rst_in = 1'b1;
    bus = '0;
    cfg = '0;
    num_errors = 0;
    comparisons = 0;
    num_caps = 0;
    num_irqs = 0;
    num_cap0 = 0;
    model_reg = TCIR_ROUTE_RESET;
    cnt_prev = 16'h0000;
    cap0_prev = 16'h0000;
    run_prev = 1'b0;
    tout_prev = 1'b0;
    repeat (2) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    reg_rd(TCIR_ROUTE_ADDR, TCIR_ROUTE_RESET);
    check(rx, 1'b1);
    reg_rd(16'hFF4E, 8'h00);
    reg_wr(8'hFF);
    reg_rd(TCIR_ROUTE_ADDR, model_reg);
    reg_wr(8'h20);
    reg_rd(TCIR_ROUTE_ADDR, model_reg);
    reg_wr(8'h10);
    reg_rd(TCIR_ROUTE_ADDR, model_reg);
    reg_bit(3'h4, 1'b1);
    reg_rd(TCIR_ROUTE_ADDR, model_reg);
    reg_bit(3'h7, 1'b1);
    reg_rd(TCIR_ROUTE_ADDR, model_reg);
    reg_bit(3'h5, 1'b0);
    reg_rd(TCIR_ROUTE_ADDR, model_reg);
    for (int i = 0; i < 24; i++)
    begin
      v = $random(seed);
      p = v[6:0];
      if (v[12])
        v[11] = 1'b1;
      partner.set_pins(p);
      reg_wr({2'b00, v[12], 1'b0, v[11:8]});
      repeat (4) @(posedge clk_sys_in);
      #1;
      exp_rx = model_reg[5] ? p.shared_rx_pin
             : (model_reg[3] ? p.serial_receive_pin : TCIR_RX_BLOCKED_LVL);
      check(rx, exp_rx);
      check(ext, model_reg[0] ? exp_rx : p.external_irq_pin);
      check(cnt2, model_reg[2] ? (p.second_timer_count_in
            & p.gate_timer_out) : p.second_timer_count_in);
      check(tx_sh, model_reg[5]);
    end
    reg_wr(8'h00);
    p = '0;
    p.primary_trigger_pin = 1'b1;
    partner.set_pins(p);
    repeat (6) @(posedge clk_sys_in);
    cfg <= '{run: 1'b1, clear_start: 1'b1, count_on_trig: 1'b0,
             cr0_capture: 1'b0, reverse_phase: 1'b0, out_en: 1'b1,
             presc_sel: 2'h0, pri_edge: TCIR_EDGE_RISE,
             sec_edge: TCIR_EDGE_NONE, compare: 16'h0001};
    repeat (40) @(posedge clk_sys_in);
    exp_caps = 1;
    check(16'(num_caps), 16'(exp_caps));
    partner.set_pins('0);
    repeat (20) @(posedge clk_sys_in);
    repeat (3) partner.pulse_primary(10, 30);
    exp_caps += 3;
    check(16'(num_caps), 16'(exp_caps));
    partner.pulse_primary(1, 30);
    check(16'(num_caps), 16'(exp_caps));
    check(16'(num_irqs), 16'(exp_caps + 1));
    cfg.run <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    partner.pulse_primary(10, 20);
    check(cnt, TCIR_CNT_RESET);
    check(16'(num_caps), 16'(exp_caps));
    partner.set_pins(p);
    repeat (10) @(posedge clk_sys_in);
    cfg.run <= 1'b1;
    repeat (40) @(posedge clk_sys_in);
    check(16'(num_caps), 16'(exp_caps));
    check(16'(num_irqs), 16'(exp_caps + 2));
    cfg.count_on_trig <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    check(conflict, 1'b1);
    // Capture mode, then reverse phase, on a slower count clock
    @(posedge clk_sys_in);
    cfg <= '{run: 1'b1, clear_start: 1'b0, count_on_trig: 1'b0,
             cr0_capture: 1'b1, reverse_phase: 1'b0, out_en: 1'b1,
             presc_sel: 2'h1, pri_edge: TCIR_EDGE_RISE,
             sec_edge: TCIR_EDGE_RISE, compare: 16'h0001};
    partner.pulse_secondary(20, 30);
    check(16'(num_cap0), 16'h0001);
    check(16'(num_irqs), 16'(exp_caps + 3));
    cfg.reverse_phase <= 1'b1;
    partner.pulse_primary(20, 30);
    check(16'(num_cap0), 16'h0002);
    check(16'(num_irqs), 16'(exp_caps + 3));
    partner.pulse_secondary(20, 30);
    check(16'(num_cap0), 16'h0002);
    check(16'(num_irqs), 16'(exp_caps + 4));
    give_verdict();
  end

endmodule : tb_timer_capture_input_routing
